// ---- core/uart_flow_defs.svh ----
`ifndef UART_FLOW_DEFS_SVH
`define UART_FLOW_DEFS_SVH

// ----------------------------------------------------------------
// Command, select and mode codes
// ----------------------------------------------------------------
`define CMD_ASSERT_RTS      4'h8
`define CLKSEL_TIMER_16X    4'hD
`define CLKSEL_EXT_16X      4'hE
`define CLKSEL_EXT_1X       4'hF
`define AUXCTL_CNT_EXT_1X   3'h0
`define AUXCTL_CNT_EXT_16X  3'h1
`define AUXCTL_TMR_EXT_1X   3'h4
`define AUXCTL_TMR_EXT_16X  3'h5
`define AUXCTL_TMR_SYS_1X   3'h6
`define AUXCTL_TMR_SYS_16X  3'h7
`define AUXCTL_TIMER_BIT    2
`define OUTCFG_RTS_CODE     3'h0

// ----------------------------------------------------------------
// Bit positions of mode fields
// ----------------------------------------------------------------
`define MODE1_RX_RTS_BIT    7
`define MODE2_CTS_EN_BIT    4
`define MODE2_TX_RTS_BIT    5

// ----------------------------------------------------------------
// Register selects on the host strobe port
// ----------------------------------------------------------------
`define SEL_STATUS          2'h0
`define SEL_INPUT_LEVEL     2'h1
`define SEL_INPUT_CHANGE    2'h2
`define SEL_WR_HOLDING      2'h0
`define SEL_WR_COMMAND      2'h1

// ----------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------
`define PRESCALE_LAST       4'hF
`define DATA_BITS_LAST      3'h7
`define TIMER_DIV_MIN       16'h0002
`define MARK_LEVEL          1'b1
`define CLK_MHZ             200
`define REF_CLK_MHZ         4
`define RATE_1X_MAX_KBPS    1000
`define RATE_16X_MAX_KBPS   62

`endif

// ---- core/uart_flow_pkg.sv ----
package uart_flow_pkg;

    typedef enum logic [4:0] {
        TX_IDLE   = 5'b00001,
        TX_START  = 5'b00010,
        TX_DATA   = 5'b00100,
        TX_STOP   = 5'b01000,
        TX_LINGER = 5'b10000
    } tx_state_e;

    typedef struct packed {
        logic [1:0]  aux_prev;
        logic        timer_prev;
        tx_state_e   st;
        logic [7:0]  hold;
        logic        hold_full;
        logic [7:0]  shift;
        logic [2:0]  bitn;
        logic [3:0]  pre;
        logic        txd;
        logic        rts;
        logic        rts_auto_off;
        logic        wr_prev;
        logic        rd_prev;
        logic [2:0]  status;
        logic [3:0]  levels;
        logic [1:0]  change;
        logic [7:0]  rdata;
        logic        pin_out;
        logic        rx_tick;
        logic        rx_1x;
    } chan_state_s;

    typedef struct packed {
        logic        aux_prev;
        logic [3:0]  pre;
        logic [15:0] cnt;
        logic        out;
        logic        done;
    } timer_state_s;

endpackage

// ---- core/baud_timer.sv ----
`timescale 1ns/1ps
`include "uart_flow_defs.svh"

module baud_timer #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             aux_input_one,
    input  wire logic             aux_clock_owner,
    input  wire logic [2:0]       timer_mode,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  timer_output,
    output logic                  counter_done
);

    uart_flow_pkg::timer_state_s s_r, s_nxt;
    logic tick;
    logic ext_edge;

    // ----------------------------------------------------------------
    // Timer clock source and square wave
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.aux_prev = aux_input_one;
        ext_edge = aux_clock_owner && aux_input_one && !s_r.aux_prev; // [R17] [R18]
        tick = 1'b0;
        unique case (timer_mode)
            `AUXCTL_CNT_EXT_1X, `AUXCTL_TMR_EXT_1X: begin
                tick = ext_edge;
            end
            `AUXCTL_CNT_EXT_16X, `AUXCTL_TMR_EXT_16X: begin
                tick = ext_edge && (s_r.pre == `PRESCALE_LAST);
            end
            `AUXCTL_TMR_SYS_1X: begin
                tick = 1'b1;
            end
            `AUXCTL_TMR_SYS_16X: begin
                tick = (s_r.pre == `PRESCALE_LAST);
            end
            default: begin
                tick = 1'b0;
            end
        endcase
        if ((timer_mode == `AUXCTL_TMR_SYS_16X) ||
            (ext_edge && (timer_mode[1:0] == 2'h1))) begin
            s_nxt.pre = s_r.pre + 4'h1;
        end
        s_nxt.done = 1'b0;
        if (tick) begin
            // Half period is the divisor, so the full wave spans twice it
            if (s_r.cnt <= DIV_W'(1)) begin // [R1] [R26]
                s_nxt.cnt = divisor;
                if (timer_mode[`AUXCTL_TIMER_BIT]) begin
                    s_nxt.out = !s_r.out;
                end else begin
                    s_nxt.done = 1'b1;
                end
            end else begin
                s_nxt.cnt = s_r.cnt - DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign timer_output = s_r.out;
    assign counter_done = s_r.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // First half period after a mode change starts from a stale count, so skip it
    logic [DIV_W-1:0] since_r;
    logic             armed_r;
    always_ff @(posedge clk) begin
        if (!nrst || (s_r.out != s_nxt.out) || (timer_mode != `AUXCTL_TMR_SYS_1X)) begin
            since_r <= '0;
        end else begin
            since_r <= since_r + DIV_W'(1);
        end
        if (!nrst || (timer_mode != `AUXCTL_TMR_SYS_1X)) begin
            armed_r <= 1'b0;
        end else if (s_r.out != s_nxt.out) begin
            armed_r <= 1'b1;
        end
    end

    AST_TIMER_HALF_PERIOD: assert property (@(posedge clk) disable iff (!nrst) // [R1]
        (timer_mode == `AUXCTL_TMR_SYS_1X) && armed_r && $stable(divisor)
        && (divisor >= `TIMER_DIV_MIN) && (s_r.out != s_nxt.out)
        |-> (since_r + DIV_W'(1) == divisor))
        else $error("timer half period differs from divisor");

    AST_TIMER_NO_OWNER: assert property (@(posedge clk) disable iff (!nrst) // [R19]
        !aux_clock_owner && (timer_mode == `AUXCTL_TMR_EXT_1X) |=> $stable(s_r.out))
        else $error("timer clocked by a pin it does not own");

endmodule

// ---- core/uart_flow_channel.sv ----
`timescale 1ns/1ps
`include "uart_flow_defs.svh"

// Behaviour
// R1: timer 1X rate is clock over twice divisor
// R2: 1X timer clock supports 1Mbps at 4MHz
// R3: 16X timer divisor two gives 62.5Kbps
// R4: 1X timer receive clock needs synchronised data
// R5: receiver may own send request on output
// R6: command 1000 asserts send request
// R7: full FIFO start bit drops request, slot restores
// R8: input zero gates transmitter as clear-to-send
// R9: clear-to-send loss finishes character, marks, stops clock
// R10: empty status held clear until clear-to-send returns
// R11: remote sender stops after current character
// R12: transmitter may own request for whole message
// R13: software asserts request, disables after last load
// R14: final character sent, request drops one bit later
// R15: live input levels readable by host
// R16: inputs zero, one flagged on change
// R17: aux field 000/001 route input one to counter
// R18: aux field 100/101 route input one to timer
// R19: second channel input one stays general purpose
// R20: clock select 1110/1111 take input two for transmit
// R21: clock select 1110/1111 take input three for receive
// R22: internal strobes are chip enable ANDed with strobes
// R23: host negates read strobe between reads
// R24: status updates only while read strobe negated
// R25: clock select 1101 takes timer as 16X clock
// R26: divisor at least two, square wave output
module uart_flow_channel #(
    parameter bit FIRST_CHANNEL = 1'b1,
    parameter int DIV_W         = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             chip_enable_n,
    input  wire logic             read_strobe_n,
    input  wire logic             write_strobe_n,
    input  wire logic [1:0]       reg_select,
    input  wire logic [7:0]       write_data,
    output logic      [7:0]       read_data,
    input  wire logic [7:0]       mode_register_one,
    input  wire logic [7:0]       mode_register_two,
    input  wire logic [7:0]       output_configuration_register,
    input  wire logic [7:0]       clock_select_register,
    input  wire logic [2:0]       auxiliary_control_register,
    input  wire logic [DIV_W-1:0] timer_divisor,
    input  wire logic             tx_enable,
    input  wire logic             baud_gen_16x_tick,
    input  wire logic             aux_input_zero,
    input  wire logic             aux_input_one,
    input  wire logic             aux_input_two,
    input  wire logic             aux_input_three,
    input  wire logic             rx_start_bit,
    input  wire logic             rx_fifo_full,
    input  wire logic             output_alt_level,
    output logic                  serial_out,
    output logic                  multi_purpose_output,
    output logic                  rx_clock_tick,
    output logic                  rx_clock_is_1x,
    output logic                  timer_output,
    output logic                  counter_done,
    output logic                  aux_one_general_purpose,
    output logic                  input_change_pending
);

    uart_flow_pkg::chan_state_s s_r, s_nxt;
    logic rd_int, wr_int, wr_event, rd_event;
    logic cts_ok, tx_src, tx_1x, bit_tick, owner, t_edge;
    logic [3:0] levels;

    // ----------------------------------------------------------------
    // Clock source helpers shared by both directions
    // ----------------------------------------------------------------
    function automatic logic src_tick(input logic [3:0] code, input logic tmr_edge,
                                      input logic ext_edge, input logic brg);
        unique case (code)
            `CLKSEL_TIMER_16X:               src_tick = tmr_edge; // [R25]
            `CLKSEL_EXT_16X, `CLKSEL_EXT_1X: src_tick = ext_edge;
            default:                   src_tick = brg;
        endcase
    endfunction

    function automatic logic is_1x(input logic [3:0] code);
        is_1x = (code == `CLKSEL_EXT_1X);
    endfunction

    // ----------------------------------------------------------------
    // Block counter/timer
    // ----------------------------------------------------------------
    // Only the first channel of a block owns the timer clock pin
    assign owner = FIRST_CHANNEL; // [R19]

    baud_timer #(
        .DIV_W (DIV_W)
    ) u_timer (
        .clk             (clk),
        .nrst            (nrst),
        .aux_input_one   (aux_input_one),
        .aux_clock_owner (owner),
        .timer_mode      (auxiliary_control_register),
        .divisor         (timer_divisor),
        .timer_output    (timer_output),
        .counter_done    (counter_done)
    );

    assign aux_one_general_purpose = !owner || auxiliary_control_register[1]; // [R17] [R18] [R19]

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        rd_int = !chip_enable_n && !read_strobe_n; // [R22]
        wr_int = !chip_enable_n && !write_strobe_n; // [R22]
        // Act once per strobe, at the later assertion of the pair
        wr_event = wr_int && !s_r.wr_prev;
        rd_event = rd_int && !s_r.rd_prev;
        s_nxt.wr_prev = wr_int;
        s_nxt.rd_prev = rd_int;
        levels = {aux_input_three, aux_input_two, aux_input_one, aux_input_zero};
        s_nxt.aux_prev = {aux_input_three, aux_input_two};
        s_nxt.timer_prev = timer_output;
        t_edge = timer_output && !s_r.timer_prev;
        // Clear-to-send is active low on input zero when enabled
        cts_ok = !mode_register_two[`MODE2_CTS_EN_BIT] || !aux_input_zero; // [R8]

        // Clock selection for both directions
        tx_src = src_tick(clock_select_register[3:0], t_edge,
                          aux_input_two && !s_r.aux_prev[0], baud_gen_16x_tick); // [R20]
        tx_1x = is_1x(clock_select_register[3:0]); // [R2] [R20]
        s_nxt.rx_tick = src_tick(clock_select_register[7:4], t_edge,
                                 aux_input_three && !s_r.aux_prev[1],
                                 baud_gen_16x_tick); // [R21] [R4]
        s_nxt.rx_1x = is_1x(clock_select_register[7:4]); // [R21]

        // Bit clock stands still while idle, so a stalled sender stays marking
        bit_tick = 1'b0;
        if (s_r.st != uart_flow_pkg::TX_IDLE) begin
            if (tx_src) begin
                s_nxt.pre = s_r.pre + 4'h1;
            end
            bit_tick = tx_src && (tx_1x || (s_r.pre == `PRESCALE_LAST)); // [R3]
        end else begin
            s_nxt.pre = '0;
        end

        // Holding register writes
        if (wr_event && (reg_select == `SEL_WR_HOLDING) && tx_enable && !s_r.hold_full) begin
            s_nxt.hold = write_data;
            s_nxt.hold_full = 1'b1;
        end

        // Transmitter
        unique case (s_r.st)
            uart_flow_pkg::TX_IDLE: begin
                s_nxt.txd = `MARK_LEVEL; // [R9]
                if (s_r.hold_full && cts_ok) begin // [R9] [R10]
                    s_nxt.shift = s_r.hold;
                    s_nxt.hold_full = 1'b0;
                    s_nxt.st = uart_flow_pkg::TX_START;
                    s_nxt.txd = 1'b0;
                end
            end
            uart_flow_pkg::TX_START: begin
                if (bit_tick) begin
                    s_nxt.txd = s_r.shift[0];
                    s_nxt.bitn = '0;
                    s_nxt.st = uart_flow_pkg::TX_DATA;
                end
            end
            uart_flow_pkg::TX_DATA: begin
                if (bit_tick) begin
                    if (s_r.bitn == `DATA_BITS_LAST) begin
                        s_nxt.txd = `MARK_LEVEL;
                        s_nxt.st = uart_flow_pkg::TX_STOP;
                    end else begin
                        s_nxt.shift = {1'b0, s_r.shift[7:1]};
                        s_nxt.txd = s_r.shift[1];
                        s_nxt.bitn = s_r.bitn + 3'h1;
                    end
                end
            end
            uart_flow_pkg::TX_STOP: begin
                // A character in progress always completes
                if (bit_tick) begin // [R9]
                    if (mode_register_two[`MODE2_TX_RTS_BIT] && !tx_enable
                        && !s_r.hold_full) begin // [R14]
                        s_nxt.st = uart_flow_pkg::TX_LINGER;
                    end else begin
                        s_nxt.st = uart_flow_pkg::TX_IDLE;
                    end
                end
            end
            uart_flow_pkg::TX_LINGER: begin
                if (bit_tick) begin
                    s_nxt.rts = 1'b0; // [R14] [R12]
                    s_nxt.st = uart_flow_pkg::TX_IDLE;
                end
            end
        endcase

        // Send request from the receiver side
        if (mode_register_one[`MODE1_RX_RTS_BIT]) begin
            if (rx_start_bit && rx_fifo_full) begin // [R7]
                s_nxt.rts = 1'b0;
                s_nxt.rts_auto_off = 1'b1;
            end else if (s_r.rts_auto_off && !rx_fifo_full) begin // [R7]
                s_nxt.rts = 1'b1;
                s_nxt.rts_auto_off = 1'b0;
            end
        end
        // Software command wins over automatic negation in the same cycle
        if (wr_event && (reg_select == `SEL_WR_COMMAND)
            && (write_data[7:4] == `CMD_ASSERT_RTS)) begin // [R6] [R13]
            s_nxt.rts = 1'b1;
            s_nxt.rts_auto_off = 1'b0;
        end
        // Pin carries the request only when both output fields select it
        if ((output_configuration_register[6:4] == `OUTCFG_RTS_CODE)
            && (output_configuration_register[2:0] == `OUTCFG_RTS_CODE)) begin // [R5]
            s_nxt.pin_out = !s_nxt.rts;
        end else begin
            s_nxt.pin_out = output_alt_level;
        end

        // Input port: live levels and change flags, set beating clear
        s_nxt.levels = levels; // [R15]
        if (rd_event && (reg_select == `SEL_INPUT_CHANGE)) begin
            s_nxt.change = '0;
        end
        s_nxt.change = s_nxt.change | (levels[1:0] ^ s_r.levels[1:0]); // [R16]

        // Status holds still through a read so the host sees a steady word
        if (!rd_int) begin // [R24] [R23]
            s_nxt.status[0] = !s_r.hold_full;
            s_nxt.status[1] = (s_r.st == uart_flow_pkg::TX_IDLE) && !s_r.hold_full
                              && cts_ok; // [R10]
            s_nxt.status[2] = s_r.rts;
        end
        if (rd_event) begin
            unique case (reg_select)
                `SEL_STATUS:       s_nxt.rdata = {5'h00, s_r.status};
                `SEL_INPUT_LEVEL:  s_nxt.rdata = {4'h0, s_r.levels}; // [R15]
                `SEL_INPUT_CHANGE: s_nxt.rdata = {2'h0, s_r.change, 2'h0,
                                                  s_r.levels[1:0]}; // [R16]
                default:           s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_r <= '{st: uart_flow_pkg::TX_IDLE, txd: `MARK_LEVEL, pin_out: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign serial_out           = s_r.txd;
    assign multi_purpose_output = s_r.pin_out;
    assign read_data            = s_r.rdata;
    assign rx_clock_tick        = s_r.rx_tick;
    assign rx_clock_is_1x       = s_r.rx_1x;
    assign input_change_pending = |s_r.change; // [R16]

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence seq_cmd_rts;
        wr_event && (reg_select == `SEL_WR_COMMAND) && (write_data[7:4] == `CMD_ASSERT_RTS);
    endsequence

    sequence seq_full_start;
        mode_register_one[`MODE1_RX_RTS_BIT] && rx_start_bit && rx_fifo_full
        && !(wr_event && (reg_select == `SEL_WR_COMMAND)
        && (write_data[7:4] == `CMD_ASSERT_RTS));
    endsequence

    AST_CMD_ASSERTS_RTS: assert property (@(posedge clk) disable iff (!nrst) // [R6]
        seq_cmd_rts |=> s_r.rts)
        else $error("send request not asserted by command");

    AST_FULL_DROPS_RTS: assert property (@(posedge clk) disable iff (!nrst) // [R7]
        seq_full_start |=> !s_r.rts ##1 (!s_r.rts || !rx_fifo_full))
        else $error("send request kept with full receive queue");

    AST_SLOT_RESTORES_RTS: assert property (@(posedge clk) disable iff (!nrst) // [R7]
        mode_register_one[`MODE1_RX_RTS_BIT] && s_r.rts_auto_off && !rx_fifo_full |=> s_r.rts)
        else $error("send request not restored after slot freed");

    AST_PIN_FOLLOWS_RTS: assert property (@(posedge clk) disable iff (!nrst) // [R5]
        (output_configuration_register == 8'h00) |=> (s_r.pin_out == !s_r.rts))
        else $error("output pin does not carry send request");

    AST_CTS_WITHHOLDS: assert property (@(posedge clk) disable iff (!nrst) // [R9]
        (s_r.st == uart_flow_pkg::TX_IDLE) && !cts_ok |=> (s_r.st == uart_flow_pkg::TX_IDLE)
        && s_r.txd)
        else $error("character started without clear-to-send");

    AST_EMPTY_CLEAR_NO_CTS: assert property (@(posedge clk) disable iff (!nrst) // [R10]
        !cts_ok && !rd_int |=> !s_r.status[1])
        else $error("empty status set while clear-to-send negated");

    AST_STATUS_FROZEN: assert property (@(posedge clk) disable iff (!nrst) // [R24]
        rd_int |=> $stable(s_r.status))
        else $error("status changed during active read");

    AST_STROBE_AND: assert property (@(posedge clk) disable iff (!nrst) // [R22]
        (chip_enable_n || read_strobe_n) && (reg_select == `SEL_STATUS)
        |=> $stable(read_data))
        else $error("read taken without both strobes");

    AST_TX_RTS_LINGER: assert property (@(posedge clk) disable iff (!nrst) // [R14]
        (s_r.st == uart_flow_pkg::TX_LINGER) && !bit_tick |=> s_r.rts || $past(!s_r.rts))
        else $error("send request dropped before one bit time elapsed");

    AST_CHANGE_FLAG: assert property (@(posedge clk) disable iff (!nrst) // [R16]
        (aux_input_zero != s_r.levels[0]) |=> s_r.change[0])
        else $error("change of input zero not flagged");

    AST_EXT_1X_TICK: assert property (@(posedge clk) disable iff (!nrst) // [R20]
        (clock_select_register[3:0] == `CLKSEL_EXT_1X) && (s_r.st == uart_flow_pkg::TX_DATA)
        && aux_input_two && !s_r.aux_prev[0] |-> bit_tick)
        else $error("external 1X edge did not advance a bit");

endmodule

// ---- test/serial_sink.sv ----
`timescale 1ns/1ps

// Far-end receiver: samples mid-bit, 16 cycles a bit, LSB first, stop in bit 8
module serial_sink (
    input  wire logic       clk,
    input  wire logic       line,
    output logic [8:0]      word,
    output logic            got
);
    int i;

    initial begin
        got = 1'b0;
        word = 9'h000;
        forever begin
            @(negedge line);
            repeat (8) @(negedge clk);
            for (i = 0; i < 9; i++) begin
                repeat (16) @(negedge clk);
                word[i] = line;
            end
            got = 1'b1;
            @(negedge clk);
            got = 1'b0;
        end
    end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps

module testbench;
    logic clk = 1'b0, nrst = 1'b0, chip_enable_n = 1'b1, read_strobe_n = 1'b1;
    logic write_strobe_n = 1'b1, tx_enable = 1'b1, baud_gen_16x_tick = 1'b1;
    logic aux_input_zero = 1'b0, aux_input_one = 1'b0, aux_input_two = 1'b0;
    logic aux_input_three = 1'b0, rx_start_bit = 1'b0, rx_fifo_full = 1'b0;
    logic output_alt_level = 1'b0;
    logic [1:0] reg_select = 2'h0;
    logic [2:0] auxiliary_control_register = 3'h6;
    logic [7:0] write_data = 8'h00, mode_register_one = 8'h80, mode_register_two = 8'h00;
    logic [7:0] output_configuration_register = 8'h00, clock_select_register = 8'h00;
    logic [15:0] timer_divisor = 16'h0002;
    logic [7:0] read_data, b;
    logic serial_out, multi_purpose_output, rx_clock_tick, rx_clock_is_1x;
    logic timer_output, counter_done, aux_one_general_purpose, input_change_pending;
    logic [8:0] word;
    logic got;
    logic [8:0] exp_q[$];
    int errors = 0, tests_run = 0, cycles = 0, seed = 91932, i;

    always #2.5 clk = ~clk;

    uart_flow_channel dut_u (.clk, .nrst, .chip_enable_n, .read_strobe_n, .write_strobe_n,
        .reg_select, .write_data, .read_data, .mode_register_one, .mode_register_two,
        .output_configuration_register, .clock_select_register, .auxiliary_control_register,
        .timer_divisor, .tx_enable, .baud_gen_16x_tick, .aux_input_zero, .aux_input_one,
        .aux_input_two, .aux_input_three, .rx_start_bit, .rx_fifo_full, .output_alt_level,
        .serial_out, .multi_purpose_output, .rx_clock_tick, .rx_clock_is_1x, .timer_output,
        .counter_done, .aux_one_general_purpose, .input_change_pending);

    serial_sink sink_u (.clk(clk), .line(serial_out), .word(word), .got(got));

    task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v);
        tests_run++;
        if (got_v !== exp_v) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got_v, exp_v);
        end
    endtask

    task automatic test_done;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(posedge clk);
        chip_enable_n <= 1'b0;
        write_strobe_n <= 1'b0;
        reg_select <= s;
        write_data <= d;
        @(posedge clk);
        chip_enable_n <= 1'b1;
        write_strobe_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        chip_enable_n <= 1'b0;
        read_strobe_n <= 1'b0;
        reg_select <= s;
        repeat (2) @(posedge clk);
        #1 check(read_data & m, e);
        @(posedge clk);
        chip_enable_n <= 1'b1;
        read_strobe_n <= 1'b1;
    endtask

    task automatic send;
        b = $random(seed);
        wr(2'h0, b);
        exp_q.push_back({1'b1, b});
    endtask

    // -----------------------------------------------------------
    // Scoreboard: every received character takes the oldest note
    // -----------------------------------------------------------
    always @(posedge got) check(word, exp_q.pop_front());

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1 check({serial_out, multi_purpose_output, rx_clock_tick}, 3'b111);
        b[0] = timer_output;
        repeat (2) @(posedge clk);
        #1 check(timer_output, !b[0]);
        wr(2'h1, 8'h80);
        #1 check(multi_purpose_output, 1'b0);
        rd(2'h0, 8'h04, 8'h04);
        @(posedge clk);
        rx_fifo_full <= 1'b1;
        rx_start_bit <= 1'b1;
        @(posedge clk);
        rx_start_bit <= 1'b0;
        @(posedge clk);
        #1 check(multi_purpose_output, 1'b1);
        rx_fifo_full <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check(multi_purpose_output, 1'b0);
        for (i = 0; i < 3; i++) begin
            send();
            repeat (100) @(posedge clk);
        end
        // Clear-to-send lost mid-character with a second byte held back
        mode_register_two <= 8'h10;
        repeat (200) @(posedge clk);
        send();
        repeat (40) @(posedge clk);
        aux_input_zero <= 1'b1;
        b = $random(seed);
        wr(2'h0, b);
        repeat (300) @(posedge clk);
        #1 check(serial_out, 1'b1);
        rd(2'h0, 8'h02, 8'h00);
        exp_q.push_back({1'b1, b});
        aux_input_zero <= 1'b0;
        repeat (250) @(posedge clk);
        rd(2'h0, 8'h02, 8'h02);
        // Transmitter owns the request; disabled after the last load
        mode_register_one <= 8'h00;
        mode_register_two <= 8'h20;
        wr(2'h1, 8'h80);
        send();
        tx_enable <= 1'b0;
        @(posedge got);
        #1 check(multi_purpose_output, 1'b0);
        repeat (12) @(posedge clk);
        #1 check(multi_purpose_output, 1'b0);
        repeat (28) @(posedge clk);
        #1 check(multi_purpose_output, 1'b1);
        b = $random(seed);
        {aux_input_three, aux_input_two, aux_input_one, aux_input_zero} <= b[3:0];
        repeat (5) @(posedge clk);
        rd(2'h1, 8'h0F, {4'h0, b[3:0]});
        rd(2'h2, 8'h33, {2'h0, b[1], 1'b1, 2'h0, b[1:0]});
        aux_input_one <= ~b[1];
        repeat (5) @(posedge clk);
        #1 check(input_change_pending, 1'b1);
        rd(2'h2, 8'h33, {6'h08, ~b[1], b[0]});
        for (i = 0; i < 8; i++) begin
            auxiliary_control_register <= i[2:0];
            @(posedge clk);
            #1 check(aux_one_general_purpose, !(i inside {0, 1, 4, 5}));
        end
        clock_select_register <= 8'hF0;
        repeat (4) @(posedge clk);
        #1 check(rx_clock_is_1x, 1'b1);
        clock_select_register <= 8'hE0;
        repeat (4) @(posedge clk);
        #1 check(rx_clock_is_1x, 1'b0);
        check(exp_q.size(), 16'h0000);
        test_done();
    end
endmodule
